// ### hdl/bcp_parser.sv
// Bus command string parser with error reporting, status byte and AXI4-Lite registers
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "bcp_consts.svh"
module bcp_parser
   import bcp_pkg::*;
#(
   parameter int MS_CYCLES = `BCP_MS_NS / 1000 * `BCP_CLK_KHZ / 1000,
   parameter int ERR_SHOW_CYCLES = `BCP_ERR_SHOW_MS * `BCP_CLK_KHZ
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus adapter side
   input wire logic [7:0] rx_char,
   input wire logic rx_char_valid,
   input wire logic remote_en,
   input wire logic get_pulse,
   input wire logic spoll_rd,
   // Instrument outputs
   output var logic [7:0] status_byte_q,
   output var logic srq_q,
   output var bcp_err_t err_shown_q,
   output var bcp_opt_t scan_channel,
   output var logic scan_busy,
   output var logic irq_q,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output var logic awready_q,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output var logic wready_q,
   output var logic [1:0] bresp_q,
   output var logic bvalid_q,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output var logic arready_q,
   output var logic [31:0] rdata_q,
   output var logic [1:0] rresp_q,
   output var logic rvalid_q,
   input wire logic rready
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Command letter to store slot; bit 3 marks a known letter
   function automatic logic [3:0] cmd_slot(input logic [7:0] c);
      unique case (c)
         `BCP_CH_A: cmd_slot = {1'b1, `BCP_IX_A};
         `BCP_CH_D: cmd_slot = {1'b1, `BCP_IX_D};
         `BCP_CH_F: cmd_slot = {1'b1, `BCP_IX_F};
         `BCP_CH_L: cmd_slot = {1'b1, `BCP_IX_L};
         `BCP_CH_M: cmd_slot = {1'b1, `BCP_IX_M};
         `BCP_CH_P: cmd_slot = {1'b1, `BCP_IX_P};
         `BCP_CH_T: cmd_slot = {1'b1, `BCP_IX_T};
         `BCP_CH_W: cmd_slot = {1'b1, `BCP_IX_W};
         default: cmd_slot = 4'h0;
      endcase
   endfunction : cmd_slot

   // Largest legal option of a slot
   function automatic bcp_opt_t opt_max(input logic [2:0] ix);
      unique case (ix)
         `BCP_IX_A: opt_max = `BCP_MAX_A;
         `BCP_IX_D: opt_max = `BCP_MAX_D;
         `BCP_IX_F, `BCP_IX_L: opt_max = `BCP_MAX_CH;
         `BCP_IX_M: opt_max = `BCP_MAX_M;
         `BCP_IX_P: opt_max = `BCP_MAX_P;
         `BCP_IX_T: opt_max = `BCP_MAX_T;
         `BCP_IX_W: opt_max = `BCP_MAX_W;
      endcase
   endfunction : opt_max

   // Register offset decode, shared by both AXI channels
   function automatic logic [4:0] reg_hit(input logic [7:0] a);
      reg_hit = {a == `BCP_OFF_CONFIG, a == `BCP_OFF_STATUS, a == `BCP_OFF_IRQ_MASK,
                 a == `BCP_OFF_IRQ_STAT, 1'b0};
      reg_hit[0] = |reg_hit[4:1];
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////////
   // Character classification

   bcp_pstate_e pst_q;
   logic [2:0] cur_ix_q;
   bcp_err_t str_err_q;
   bcp_opt_t acc_w;
   logic [3:0] slot_w;
   logic is_sp, is_dot, is_digit, is_exec, is_cmd, in_opt;
   logic fin_w, opt_bad_w, fin_ok_w;
   bcp_err_t ch_err_w, str_err_w, final_err_w;
   logic end_w, commit_w, err_fire_w;

   assign slot_w = cmd_slot(rx_char);
   assign is_sp = rx_char_valid && rx_char == `BCP_CH_SPACE;
   assign is_dot = rx_char_valid && rx_char == `BCP_CH_DOT;
   assign is_digit = rx_char_valid && rx_char >= `BCP_CH_ZERO && rx_char <= `BCP_CH_NINE;
   assign is_exec = rx_char_valid && rx_char == `BCP_CH_EXEC;
   assign is_cmd = rx_char_valid && slot_w[3];
   assign in_opt = pst_q != PS_IDLE;

   // A pending command closes on the next letter or execute; no digits reads as zero
   assign fin_w = in_opt && (is_cmd || is_exec);
   assign opt_bad_w = acc_w > opt_max(cur_ix_q);
   assign fin_ok_w = fin_w && !opt_bad_w;

   // Error of this character alone; spaces never err
   always_comb begin
      ch_err_w = `BCP_ERR_NONE;
      if (fin_w && opt_bad_w) begin
         ch_err_w = `BCP_ERR_OPT;
      end else if (rx_char_valid && !is_sp && !is_exec && !is_cmd && !(in_opt && (is_digit || is_dot))) begin
         ch_err_w = `BCP_ERR_CMD;
      end
   end

   // First error of a string is kept; not remote outranks syntax
   assign str_err_w = (str_err_q == `BCP_ERR_NONE) ? ch_err_w : str_err_q;
   assign final_err_w = remote_en ? str_err_w : `BCP_ERR_NOREM;
   assign end_w = is_exec;
   assign commit_w = end_w && final_err_w == `BCP_ERR_NONE;
   assign err_fire_w = end_w && final_err_w != `BCP_ERR_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // Parser state

   // Fraction digits are swallowed, so T01.0 reads as T1
   always_ff @(posedge aclk) begin
      if (!aresetn || end_w) begin
         pst_q <= PS_IDLE;
         cur_ix_q <= 3'h0;
         str_err_q <= `BCP_ERR_NONE;
      end else if (rx_char_valid) begin
         str_err_q <= str_err_w;
         if (is_cmd) begin
            pst_q <= PS_OPT;
            cur_ix_q <= slot_w[2:0];
         end else if (is_dot && pst_q == PS_OPT) begin
            pst_q <= PS_FRAC;
         end
      end
   end

   bcp_dec_accum u_accum (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(is_cmd || end_w),
      .push(is_digit && pst_q == PS_OPT),
      .digit(rx_char[3:0]),
      .value_q(acc_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Option store: pending copy per command, applied only on a clean string

   logic [7:0][15:0] cfg_all;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_cmd
         bcp_opt_t pend_q, cfg_q, rst_w;
         logic pend_wr_q, hit_w;
         assign rst_w = (gi == `BCP_IX_F || gi == `BCP_IX_L) ? `BCP_RST_CH
                      : (gi == `BCP_IX_W ? `BCP_RST_W : `BCP_RST_OTHER);
         assign hit_w = fin_ok_w && cur_ix_q == 3'(gi);
         assign cfg_all[gi] = cfg_q;
         // Last value of a command in the string wins
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pend_q <= '0;
               pend_wr_q <= 1'b0;
               cfg_q <= rst_w;
            end else begin
               pend_q <= hit_w ? acc_w : pend_q;
               pend_wr_q <= !end_w && (pend_wr_q || hit_w);
               if (commit_w && (hit_w || pend_wr_q)) begin
                  cfg_q <= hit_w ? acc_w : pend_q;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Scan trigger

   logic scan_start_w;

   // A trigger during a running scan restarts from the first channel
   assign scan_start_w = get_pulse && cfg_all[`BCP_IX_T] == `BCP_TRIG_GET;

   bcp_scan_seq #(
      .MS_CYCLES(MS_CYCLES)
   ) u_scan (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(scan_start_w),
      .first_ch(cfg_all[`BCP_IX_F]),
      .last_ch(cfg_all[`BCP_IX_L]),
      .interval_ms(cfg_all[`BCP_IX_W]),
      .channel_q(scan_channel),
      .busy_q(scan_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status byte and service request

   logic srq_en_w;
   logic [7:0] sb_d;

   assign srq_en_w = cfg_all[`BCP_IX_M][`BCP_SRQ_ERR_BIT];

   // A poll clears, but a new error in the same cycle wins
   always_comb begin
      sb_d = spoll_rd ? 8'h00 : status_byte_q;
      if (err_fire_w) begin
         sb_d[`BCP_SB_ERR] = 1'b1;
         sb_d[3:0] = final_err_w;
         sb_d[`BCP_SB_SRQ] = sb_d[`BCP_SB_SRQ] || srq_en_w;
      end else if (!sb_d[`BCP_SB_ERR]) begin
         sb_d[3:0] = {3'h0, scan_busy};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_byte_q <= 8'h00;
         srq_q <= 1'b0;
      end else begin
         status_byte_q <= sb_d;
         srq_q <= sb_d[`BCP_SB_SRQ];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front panel error message timer

   logic [31:0] show_cnt_q;

   // A fresh error replaces the message and restarts the full hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         show_cnt_q <= '0;
         err_shown_q <= `BCP_ERR_NONE;
      end else if (err_fire_w) begin
         show_cnt_q <= 32'(ERR_SHOW_CYCLES - 1);
         err_shown_q <= final_err_w;
      end else if (show_cnt_q != 32'h0) begin
         show_cnt_q <= show_cnt_q - 32'h1;
      end else begin
         err_shown_q <= `BCP_ERR_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   bcp_irq_t irq_stat_q, irq_mask_q, irq_ev_w, irq_stat_d;
   logic stat_rd_w;

   assign irq_ev_w = {scan_start_w, commit_w, err_fire_w && final_err_w == `BCP_ERR_NOREM,
                      err_fire_w && final_err_w == `BCP_ERR_OPT,
                      err_fire_w && final_err_w == `BCP_ERR_CMD};
   // Read clears; an event in the same cycle survives
   assign irq_stat_d = (stat_rd_w ? '0 : irq_stat_q) | irq_ev_w;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data in either order

   logic [7:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic [3:0] wr_strb_q;
   logic aw_hs_w, w_hs_w, wr_go_w;
   logic [4:0] wr_hit_w;

   assign aw_hs_w = awvalid && awready_q;
   assign w_hs_w = wvalid && wready_q;
   // Both halves held until the response is taken; one write at a time
   assign wr_go_w = !awready_q && !wready_q && !bvalid_q;
   assign wr_hit_w = reg_hit(wr_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `BCP_RESP_OKAY;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_strb_q <= '0;
         irq_mask_q <= '0;
      end else begin
         if (aw_hs_w) begin
            awready_q <= 1'b0;
            wr_addr_q <= awaddr;
         end
         if (w_hs_w) begin
            wready_q <= 1'b0;
            wr_data_q <= wdata;
            wr_strb_q <= wstrb;
         end
         if (wr_go_w) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit_w[0] ? `BCP_RESP_OKAY : `BCP_RESP_SLVERR;
            if (wr_hit_w[2] && wr_strb_q[0]) begin
               irq_mask_q <= wr_data_q[4:0];
            end
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   logic ar_hs_w;
   logic [4:0] rd_hit_w;
   logic [31:0] rd_mux_w;

   assign ar_hs_w = arvalid && arready_q;
   assign rd_hit_w = reg_hit(araddr);
   assign stat_rd_w = ar_hs_w && rd_hit_w[1];
   assign rd_mux_w = rd_hit_w[1] ? {27'h0, irq_stat_q}
                   : rd_hit_w[2] ? {27'h0, irq_mask_q}
                   : rd_hit_w[3] ? {scan_channel, 7'h0, scan_busy, status_byte_q}
                   : rd_hit_w[4] ? {8'h0, cfg_all[`BCP_IX_M][7:0], cfg_all[`BCP_IX_A][3:0],
                                    cfg_all[`BCP_IX_D][3:0], cfg_all[`BCP_IX_P][1:0],
                                    cfg_all[`BCP_IX_T][1:0], err_shown_q}
                   : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `BCP_RESP_OKAY;
      end else if (ar_hs_w) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux_w;
         rresp_q <= rd_hit_w[0] ? `BCP_RESP_OKAY : `BCP_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

endmodule : bcp_parser
`default_nettype wire

// ### hdl/bcp_consts.svh
// Constants for the bus command parser: offsets, characters, limits, timing
`ifndef BCP_CONSTS_SVH
`define BCP_CONSTS_SVH
// Register byte offsets on the AXI4-Lite slave
`define BCP_OFF_IRQ_STAT 8'h00
`define BCP_OFF_IRQ_MASK 8'h04
`define BCP_OFF_STATUS 8'h08
`define BCP_OFF_CONFIG 8'h0c
`define BCP_RESP_OKAY 2'h0
`define BCP_RESP_SLVERR 2'h2
// Characters of a command string
`define BCP_CH_SPACE 8'h20
`define BCP_CH_DOT 8'h2e
`define BCP_CH_ZERO 8'h30
`define BCP_CH_NINE 8'h39
`define BCP_CH_EXEC 8'h58
`define BCP_CH_A 8'h41
`define BCP_CH_D 8'h44
`define BCP_CH_F 8'h46
`define BCP_CH_L 8'h4c
`define BCP_CH_M 8'h4d
`define BCP_CH_P 8'h50
`define BCP_CH_T 8'h54
`define BCP_CH_W 8'h57
// Command slots (index into the option store)
`define BCP_IX_A 3'h0
`define BCP_IX_D 3'h1
`define BCP_IX_F 3'h2
`define BCP_IX_L 3'h3
`define BCP_IX_M 3'h4
`define BCP_IX_P 3'h5
`define BCP_IX_T 3'h6
`define BCP_IX_W 3'h7
// Largest legal option per command
`define BCP_MAX_A 16'h0006
`define BCP_MAX_D 16'h0005
`define BCP_MAX_CH 16'h0190
`define BCP_MAX_M 16'h00ff
`define BCP_MAX_P 16'h0002
`define BCP_MAX_T 16'h0003
`define BCP_MAX_W 16'hffff
// Option reset values, GET trigger mode and SRQ enable bit
`define BCP_RST_CH 16'h0001
`define BCP_RST_W 16'h0001
`define BCP_RST_OTHER 16'h0000
`define BCP_TRIG_GET 16'h0002
`define BCP_SRQ_ERR_BIT 5
// Status byte layout and error codes
`define BCP_SB_SRQ 6
`define BCP_SB_ERR 5
`define BCP_ERR_NONE 4'h0
`define BCP_ERR_CMD 4'h1
`define BCP_ERR_OPT 4'h2
`define BCP_ERR_NOREM 4'h3
// Interrupt status bits
`define BCP_IRQ_CMD 0
`define BCP_IRQ_OPT 1
`define BCP_IRQ_NOREM 2
`define BCP_IRQ_DONE 3
`define BCP_IRQ_SCAN 4
// Timing: clock rate and error message hold time
`define BCP_CLK_KHZ 100000
`define BCP_ERR_SHOW_MS 1000
`define BCP_MS_NS 1000000
`endif

// ### hdl/bcp_pkg.sv
// Types shared by the bus command parser files
package bcp_pkg;
   typedef enum logic [1:0] {PS_IDLE, PS_OPT, PS_FRAC} bcp_pstate_e;
   typedef logic [3:0] bcp_err_t;
   typedef logic [4:0] bcp_irq_t;
   typedef logic [15:0] bcp_opt_t;
endpackage : bcp_pkg

// ### hdl/bcp_dec_accum.sv
// Decimal option accumulator for the command parser
`timescale 1ns/100ps
`default_nettype none
module bcp_dec_accum
   import bcp_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Digit stream
   input wire logic clear,
   input wire logic push,
   input wire logic [3:0] digit,
   // Accumulated value
   output var bcp_opt_t value_q
);
   logic [19:0] next_w;

   // Times ten plus digit; saturates at 16'hffff, out of range for every command but W
   assign next_w = {1'b0, value_q, 3'b000} + {3'b000, value_q, 1'b0} + {16'h0, digit};

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         value_q <= '0;
      end else if (push) begin
         value_q <= (next_w[19:16] != 4'h0) ? 16'hffff : next_w[15:0];
      end
   end
endmodule : bcp_dec_accum
`default_nettype wire

// ### hdl/bcp_scan_seq.sv
// Channel scan sequencer: first to last, one step per interval
`timescale 1ns/100ps
`default_nettype none
`include "bcp_consts.svh"
module bcp_scan_seq
   import bcp_pkg::*;
#(
   parameter int MS_CYCLES = `BCP_CLK_KHZ
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic start,
   input wire bcp_opt_t first_ch,
   input wire bcp_opt_t last_ch,
   input wire bcp_opt_t interval_ms,
   // State
   output var bcp_opt_t channel_q,
   output var logic busy_q
);
   logic [31:0] tick_q;
   bcp_opt_t ms_q;
   logic ms_w;
   logic step_w;

   // Millisecond tick, then interval count; zero interval acts as one ms
   assign ms_w = busy_q && (tick_q == 32'(MS_CYCLES - 1));
   assign step_w = ms_w && ((ms_q + 16'h0001) >= interval_ms);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_q <= '0;
         ms_q <= '0;
         channel_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         tick_q <= '0;
         ms_q <= '0;
         channel_q <= first_ch;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         tick_q <= ms_w ? '0 : tick_q + 32'h1;
         ms_q <= step_w ? '0 : (ms_w ? ms_q + 16'h0001 : ms_q);
         if (step_w) begin
            if (channel_q >= last_ch) begin
               busy_q <= 1'b0;
            end else begin
               channel_q <= channel_q + 16'h0001;
            end
         end
      end
   end
endmodule : bcp_scan_seq
`default_nettype wire

// ### test/bcp_parser_properties.sv
// Port checker for the command parser
`timescale 1ns/100ps
`default_nettype none
module bcp_parser_properties
   import bcp_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus side inputs
   input wire logic [7:0] rx_char,
   input wire logic rx_char_valid,
   input wire logic remote_en,
   input wire logic get_pulse,
   input wire logic spoll_rd,
   // Observed outputs
   input wire logic [7:0] status_byte_q,
   input wire logic srq_q,
   input wire bcp_err_t err_shown_q,
   input wire bcp_opt_t scan_channel,
   input wire logic scan_busy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Execute character seen
   wire ex_w = rx_char_valid && rx_char == 8'h58;
   // High when the next character opens a string; limits checks to whole strings
   logic fresh_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) fresh_q <= 1'b1;
      else if (rx_char_valid) fresh_q <= ex_w;
   end
   // Whole bad strings
   sequence s_bad_cmd;
      (fresh_q && rx_char_valid && rx_char == 8'h24) ##1 (ex_w && remote_en);
   endsequence
   sequence s_bad_opt;
      (fresh_q && rx_char_valid && rx_char == 8'h41) ##1 (rx_char_valid && rx_char == 8'h37) ##1 (ex_w && remote_en);
   endsequence
   ////////////////////////////////////////
   srq_bit_a: assert property (srq_q == status_byte_q[6])
      else $error("srq level differs from status bit");
   srq_err_a: assert property (status_byte_q[6] |-> status_byte_q[5])
      else $error("srq without error");
   err_code_a: assert property (status_byte_q[5] |-> status_byte_q[3:0] inside {4'h1, 4'h2, 4'h3})
      else $error("bad error code");
   poll_clear_a: assert property (spoll_rd && !ex_w |=> status_byte_q[6:5] == 2'b00)
      else $error("poll left error bits");
   no_remote_a: assert property (ex_w && !remote_en |=> status_byte_q[5] && status_byte_q[3:0] == 4'h3 && err_shown_q == 4'h3)
      else $error("no remote error missing");
   bad_cmd_a: assert property (s_bad_cmd |=> status_byte_q[5] && status_byte_q[3:0] == 4'h1 && err_shown_q == 4'h1)
      else $error("illegal command missing");
   bad_opt_a: assert property (s_bad_opt |=> status_byte_q[5] && status_byte_q[3:0] == 4'h2 && err_shown_q == 4'h2)
      else $error("illegal option missing");
   msg_hold_a: assert property ($rose(err_shown_q != 4'h0) |-> (err_shown_q != 4'h0) [*8])
      else $error("message dropped early");
   scan_step_a: assert property ($past(scan_busy) && scan_busy && $changed(scan_channel) && !$past(get_pulse)
      |-> scan_channel == $past(scan_channel) + 16'h1)
      else $error("scan skipped a channel");
endmodule : bcp_parser_properties
bind bcp_parser bcp_parser_properties u_bcp_parser_properties (.*);
`default_nettype wire

// ### test/bcp_ctrl_model.sv
// Bus controller model: command strings, trigger, remote state
`timescale 1ns/100ps
`default_nettype none
module bcp_ctrl_model (
   // Clock
   input wire logic aclk,
   // Listener side of the parser
   output var logic [7:0] rx_char,
   output var logic rx_char_valid,
   output var logic remote_en,
   output var logic get_pulse
);
   // Idle values at time zero
   initial begin
      rx_char = 8'h00;
      rx_char_valid = 1'b0;
      remote_en = 1'b1;
      get_pulse = 1'b0;
   end
   // One character per cycle, string sent as given, then valid drops
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge aclk);
         rx_char <= s[i];
         rx_char_valid <= 1'b1;
      end
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rx_char <= ~rx_char; // Idle bus shows no stale character
   endtask : send
   // Group execute trigger, one cycle
   task automatic trig();
      @(posedge aclk);
      get_pulse <= 1'b1;
      @(posedge aclk);
      get_pulse <= 1'b0;
   endtask : trig
   // Remote or local state
   task automatic remote(input logic on);
      @(posedge aclk);
      remote_en <= on;
   endtask : remote
endmodule : bcp_ctrl_model
`default_nettype wire

// ### test/bcp_parser_tb_top.sv
// Testbench for the command parser
`timescale 1ns/100ps
`default_nettype none
module bcp_parser_tb_top;
   import bcp_pkg::*;
   // Bench driven inputs
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic spoll_rd = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   // Model and design outputs
   logic [7:0] rx_char, status_byte_q;
   logic rx_char_valid, remote_en, get_pulse, srq_q, irq_q, scan_busy;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   bcp_err_t err_shown_q;
   bcp_opt_t scan_channel;
   logic [1:0] bresp_q, rresp_q, r;
   logic [31:0] rdata_q, d;
   int miscompares = 0;
   int comparisons = 0;
   always #5 aclk = ~aclk;
   ////////////////////////////////////////
   // Short counts keep the run brief
   bcp_parser #(.MS_CYCLES(4), .ERR_SHOW_CYCLES(20)) u_bcp_parser (.*);
   bcp_ctrl_model u_bcp_ctrl_model (.aclk, .rx_char, .rx_char_valid, .remote_en, .get_pulse);
   ////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask : check
   // Wait n edges, then sample settled outputs
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : tick
   // Write; address and data released as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready_q) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready_q) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid_q);
      rs = bresp_q;
      bready <= 1'b0;
   endtask : wr
   // Read one word
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready_q);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid_q);
      v = rdata_q;
      rs = rresp_q;
      rready <= 1'b0;
   endtask : rd
   // Serial poll read
   task automatic spoll();
      @(posedge aclk);
      spoll_rd <= 1'b1;
      @(posedge aclk);
      spoll_rd <= 1'b0;
      tick(1);
   endtask : spoll
   ////////////////////////////////////////
   task automatic t_reset();
      check({irq_q, scan_busy, err_shown_q, status_byte_q}, 34'h0, "reset outputs");
      rd(8'h0c, d, r);
      check({r, d}, 34'h0, "config reset");
      rd(8'h10, d, r);
      check(r, 2'h2, "unmapped read");
      wr(8'h10, 32'h1f, r);
      check(r, 2'h2, "unmapped write");
      wr(8'h08, 32'hff, r);
      check({r, status_byte_q}, 10'h0, "read-only write");
      wr(8'h04, 32'h1f, r);
      rd(8'h04, d, r);
      check({r, d}, 34'h1f, "mask");
      $display("reset test done");
   endtask : t_reset
   task automatic t_parse();
      u_bcp_ctrl_model.send("A 01.9 D3X");
      tick(1);
      check(status_byte_q, 8'h00, "clean string");
      rd(8'h0c, d, r);
      check(d, 32'h1300, "digits");
      u_bcp_ctrl_model.send("AP2X");
      rd(8'h0c, d, r);
      check(d, 32'h0380, "bare letter");
      u_bcp_ctrl_model.trig();
      tick(1);
      check(scan_busy, 1'b0, "trigger ignored");
      $display("parse test done");
   endtask : t_parse
   task automatic t_scan();
      u_bcp_ctrl_model.send("F3L5W2T2X");
      u_bcp_ctrl_model.trig();
      tick(1);
      check({scan_busy, scan_channel, status_byte_q}, {1'b1, 16'h3, 8'h01}, "scan start");
      tick(8);
      check(scan_channel, 16'h4, "step one");
      tick(8);
      check(scan_channel, 16'h5, "step two");
      tick(12);
      check(scan_busy, 1'b0, "scan end");
      $display("scan test done");
   endtask : t_scan
   task automatic t_errors();
      string s[4];
      logic [3:0] c[4];
      s = '{"$X", "@0X", "A7X", "D6X"};
      c = '{4'h1, 4'h1, 4'h2, 4'h2};
      rd(8'h00, d, r);
      check(d, 32'h18, "earlier events");
      for (int i = 0; i < 4; i++) begin
         u_bcp_ctrl_model.send(s[i]);
         tick(1);
         check({irq_q, status_byte_q}, {1'b1, 4'h2, c[i]}, "error status");
         rd(8'h00, d, r);
         check(d, (c[i] == 4'h1) ? 32'h1 : 32'h2, "irq cause");
         tick(2);
         check(irq_q, 1'b0, "irq cleared");
         spoll();
         check({err_shown_q, status_byte_q}, {c[i], 8'h00}, "poll");
         tick(20);
         check(err_shown_q, 4'h0, "message ends");
      end
      $display("error test done");
   endtask : t_errors
   task automatic t_srq();
      u_bcp_ctrl_model.send("M32X");
      u_bcp_ctrl_model.send("Q1X");
      tick(1);
      check({srq_q, status_byte_q}, 9'h161, "srq status");
      spoll();
      check(srq_q, 1'b0, "srq cleared");
      wr(8'h04, 32'h0, r);
      u_bcp_ctrl_model.remote(1'b0);
      u_bcp_ctrl_model.send("D1X");
      tick(1);
      check({irq_q, status_byte_q}, 9'h063, "no remote");
      rd(8'h00, d, r);
      check(d, 32'hd, "pending causes");
      u_bcp_ctrl_model.remote(1'b1);
      u_bcp_ctrl_model.send("D1A7X");
      rd(8'h0c, d, r);
      check(d & 32'hfffffff0, 32'h2003a0, "config kept");
      $display("srq test done");
   endtask : t_srq
   ////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // Main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      t_reset();
      t_parse();
      t_scan();
      t_errors();
      t_srq();
      results();
   end
   // Watchdog: tests need about 280 cycles, allow over twenty times that
   initial begin
      #60000;
      miscompares++;
      results();
   end
endmodule : bcp_parser_tb_top
`default_nettype wire
